// [verilog/host_activity_watchdog.sv]
// host activity watchdog: command, counter, actions, store, registers
// How it works
// - command uses group 0x05, function 0x09; answer echoes them plus settings
// - watchdog runs whenever the action flags byte is nonzero
// - any incoming host transfer clears the counter
// - outgoing streamed data packets leave the counter alone
// - on reaching the period every selected action is carried out
// - counter steps once per second tick; period spans 1 to 65535
// - flag bits pick device reset and line drive independently
// - line config: level in bit 7, index 0-19 in bits 4-0
// - write select bit 0 stores settings with erase and program
// - jumper at power-up clears stored settings, disabling the watchdog
`timescale 1ns/1ps
`include "wdog_defs.svh"
module host_activity_watchdog (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        second_tick,
  input  wire logic        restore_jumper,
  input  wire logic        host_rx_pulse,
  input  wire logic        stream_tx_pulse,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_group,
  input  wire logic [7:0]  cmd_function,
  input  wire logic [7:0]  cmd_write_select,
  input  wire logic [7:0]  cmd_options,
  input  wire logic [15:0] cmd_period,
  input  wire logic [7:0]  cmd_line_config,
  output logic             rsp_valid,
  output logic [7:0]       rsp_group,
  output logic [7:0]       rsp_function,
  output logic [7:0]       rsp_result,
  output logic [7:0]       rsp_options,
  output logic [15:0]      rsp_period,
  output logic [7:0]       rsp_line_config,
  output logic             device_reset_req,
  output logic             line_write,
  output logic [19:0]      line_write_mask,
  output logic             line_write_level,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  output logic             irq
);
  // reset release and pin synchronisers
  logic rst_meta, rst_n;
  logic tick_meta, tick_sync, tick_prev;
  logic jmp_meta, jmp_sync;
  logic tick_edge;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_prev <= 1'b0;
      jmp_meta  <= 1'b0;
      jmp_sync  <= 1'b0;
    end
    else
    begin
      tick_meta <= second_tick;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
      jmp_meta  <= restore_jumper;
      jmp_sync  <= jmp_meta;
    end
  end

  // the tick is counted on its rising edge only
  assign tick_edge = tick_sync & ~tick_prev;

  wdog_cfg_if cfg_bus ();
  wdog_pkg::wdog_cfg_s cfg, next_cfg;
  assign cfg_bus.cfg = cfg;

  logic        expire;
  logic [15:0] count;
  logic        activity;

  // outgoing stream packets are deliberately not an input here
  assign activity = host_rx_pulse | cmd_valid;

  expiry_counter u_counter (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (tick_edge),
    .clear    (activity),
    .cfg_port (cfg_bus.dst),
    .expire   (expire),
    .count    (count)
  );

  logic        st_wr, st_rd, st_busy;
  logic [31:0] st_wdata, st_rdata;
  logic [15:0] st_wear;

  settings_store u_store (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_req  (st_wr),
    .wr_data (st_wdata),
    .rd_req  (st_rd),
    .busy    (st_busy),
    .rd_data (st_rdata),
    .wear    (st_wear)
  );

  function automatic logic [19:0] line_decode(input logic [7:0] lc);
    logic [4:0] idx;
    idx = lc[`LCFG_INDEX_MSB:0];
    if (idx < 5'(`LINE_COUNT))
      return 20'(20'h00001 << idx);
    return 20'h00000;
  endfunction

  // boot restore, command handling and the settings they change
  wdog_pkg::boot_e boot, next_boot;
  logic [1:0] settle, next_settle;
  logic       next_rsp_valid;
  logic [7:0] next_result;
  logic       cmd_ok, cmd_wr, rejected, stored;

  assign cmd_ok = cmd_group == `CMD_GROUP &&
                  cmd_function == `CMD_FUNCTION;
  assign cmd_wr = cmd_write_select[`WSEL_WRITE_BIT];

  always_comb
  begin
    next_boot      = boot;
    next_settle    = settle;
    next_cfg       = cfg;
    next_rsp_valid = 1'b0;
    next_result    = rsp_result;
    st_wr          = 1'b0;
    st_rd          = 1'b0;
    st_wdata       = cfg;
    rejected       = 1'b0;
    stored         = 1'b0;
    case (boot)
      wdog_pkg::BOOT_WAIT:
        if (settle != `BOOT_SETTLE)
          next_settle = settle + 2'h1;
        else if (jmp_sync)
        begin
          next_cfg  = '0;
          st_wr     = 1'b1;
          st_wdata  = 32'h00000000;
          next_boot = wdog_pkg::BOOT_RUN;
        end
        else
        begin
          st_rd     = 1'b1;
          next_boot = wdog_pkg::BOOT_LOAD;
        end
      wdog_pkg::BOOT_LOAD:
      begin
        next_cfg  = st_rdata;
        next_boot = wdog_pkg::BOOT_RUN;
      end
      wdog_pkg::BOOT_RUN: ;
      default: next_boot = wdog_pkg::BOOT_WAIT;
    endcase
    if (cmd_valid)
    begin
      next_rsp_valid = 1'b1;
      next_result    = `RES_OK;
      if (!cmd_ok)
      begin
        next_result = `RES_BAD_CMD;
        rejected    = 1'b1;
      end
      else if (cmd_wr && (boot != wdog_pkg::BOOT_RUN || st_busy))
      begin
        next_result = `RES_BUSY;
        rejected    = 1'b1;
      end
      else if (cmd_wr)
      begin
        next_cfg = '{line_config: cmd_line_config, period: cmd_period,
                     options: cmd_options};
        st_wr    = 1'b1;
        st_wdata = next_cfg;
        stored   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot       <= wdog_pkg::BOOT_WAIT;
      settle     <= 2'h0;
      cfg        <= '0;
      rsp_valid  <= 1'b0;
      rsp_result <= `RES_OK;
    end
    else
    begin
      boot       <= next_boot;
      settle     <= next_settle;
      cfg        <= next_cfg;
      rsp_valid  <= next_rsp_valid;
      rsp_result <= next_result;
    end
  end

  // answer echoes the codes and the settings now in force
  assign rsp_group       = `CMD_GROUP;
  assign rsp_function    = `CMD_FUNCTION;
  assign rsp_options     = cfg.options;
  assign rsp_period      = cfg.period;
  assign rsp_line_config = cfg.line_config;

  // expiry actions, one-cycle pulses; a line index above 19 does nothing
  logic        next_dev_rst, next_line_wr, next_level;
  logic [19:0] next_mask;

  always_comb
  begin
    next_dev_rst = expire && cfg.options[`OPT_RESET_BIT];
    next_line_wr = expire && cfg.options[`OPT_LINE_BIT];
    next_mask    = next_line_wr ? line_decode(cfg.line_config) : 20'h00000;
    next_level   = next_line_wr ? cfg.line_config[`LCFG_LEVEL_BIT]
                                : line_write_level;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      device_reset_req <= 1'b0;
      line_write       <= 1'b0;
      line_write_mask  <= 20'h00000;
      line_write_level <= 1'b0;
    end
    else
    begin
      device_reset_req <= next_dev_rst;
      line_write       <= next_line_wr;
      line_write_mask  <= next_mask;
      line_write_level <= next_level;
    end
  end

  // register slave and interrupt; a new event beats a clear
  logic [`EV_WIDTH-1:0] status, next_status, enable, next_enable;
  logic [`EV_WIDTH-1:0] events;
  logic [31:0]          next_rdata;

  assign events = {rejected, stored, expire};

  always_comb
  begin
    next_status = status;
    next_enable = enable;
    if (reg_write && reg_addr == `REG_CLEAR)
      next_status = status & ~reg_wdata[`EV_WIDTH-1:0];
    next_status = next_status | events;
    if (reg_write && reg_addr == `REG_ENABLE)
      next_enable = reg_wdata[`EV_WIDTH-1:0];
    next_rdata = 32'h00000000;
    if (reg_read)
      case (reg_addr)
        `REG_STATUS: next_rdata = 32'(status);
        `REG_ENABLE: next_rdata = 32'(enable);
        `REG_CONFIG: next_rdata = cfg;
        `REG_COUNT:  next_rdata = {st_wear, count};
        default:     next_rdata = 32'h00000000;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status    <= '0;
      enable    <= '0;
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      status    <= next_status;
      enable    <= next_enable;
      reg_rdata <= next_rdata;
    end
  end

  assign irq = |(status & enable);

  sequence s_expire_reset;
    expire && cfg.options[`OPT_RESET_BIT];
  endsequence
  sequence s_quiet_stream;
    stream_tx_pulse && !activity && !tick_edge && |cfg.options;
  endsequence

  a_reset_action: assert property (@(posedge clk) disable iff (!rst_n)
    s_expire_reset |=> device_reset_req)
    else $error("reset action missing on expiry");
  a_line_action: assert property (@(posedge clk) disable iff (!rst_n)
    line_write |-> $past(expire) && line_write_mask ==
      line_decode($past(cfg.line_config)) &&
      line_write_level == $past(cfg.line_config[`LCFG_LEVEL_BIT]))
    else $error("line action does not match config");
  a_stream_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    s_quiet_stream |=> count == $past(count))
    else $error("stream packet changed the counter");
  a_answer_codes: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid |=> rsp_valid && rsp_group == 8'h05 &&
      rsp_function == 8'h09 && (rsp_result == `RES_BAD_CMD) == !$past(cmd_ok))
    else $error("answer missing or malformed");
  a_write_stores: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_ok && cmd_wr && boot == wdog_pkg::BOOT_RUN &&
      !st_busy |=> st_busy && cfg.period == $past(cmd_period))
    else $error("accepted write not stored");
  a_jumper_clear: assert property (@(posedge clk) disable iff (!rst_n)
    boot == wdog_pkg::BOOT_WAIT && settle == `BOOT_SETTLE && jmp_sync
      |=> cfg == '0 && st_busy)
    else $error("jumper did not clear settings");
endmodule

// [verilog/wdog_defs.svh]
// constants for the host activity watchdog
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH
`define CMD_GROUP       8'h05
`define CMD_FUNCTION    8'h09
`define WSEL_WRITE_BIT  0
`define OPT_LINE_BIT    4
`define OPT_RESET_BIT   5
`define LCFG_LEVEL_BIT  7
`define LCFG_INDEX_MSB  4
`define LINE_COUNT      20
`define RES_OK          8'h00
`define RES_BAD_CMD     8'h01
`define RES_BUSY        8'h02
`define REG_STATUS      8'h00
`define REG_CLEAR       8'h04
`define REG_ENABLE      8'h08
`define REG_CONFIG      8'h0C
`define REG_COUNT       8'h10
`define EV_EXPIRED      0
`define EV_STORED       1
`define EV_REJECTED     2
`define EV_WIDTH        3
`define CLK_MHZ         125
`define ERASE_TIME_NS   2000
`define PROGRAM_TIME_NS 400
`define BOOT_SETTLE     2'h3
`endif

// [verilog/wdog_pkg.sv]
// types shared by the watchdog modules
package wdog_pkg;
  typedef enum logic [1:0] {BOOT_WAIT, BOOT_LOAD, BOOT_RUN} boot_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROGRAM} store_e;
  typedef struct packed {
    logic [7:0]  line_config;
    logic [15:0] period;
    logic [7:0]  options;
  } wdog_cfg_s;
endpackage

// [verilog/wdog_cfg_if.sv]
// live watchdog settings passed from the top to the counter
`timescale 1ns/1ps
interface wdog_cfg_if;
  wdog_pkg::wdog_cfg_s cfg;
  modport src (output cfg);
  modport dst (input cfg);
endinterface

// [verilog/settings_store.sv]
// non-volatile settings word with erase and program cycle
`timescale 1ns/1ps
`include "wdog_defs.svh"
module settings_store #(
  parameter int ERASE_NS   = `ERASE_TIME_NS,
  parameter int PROGRAM_NS = `PROGRAM_TIME_NS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_req,
  input  wire logic [31:0] wr_data,
  input  wire logic        rd_req,
  output logic             busy,
  output logic [31:0]      rd_data,
  output logic [15:0]      wear
);
  function automatic logic [11:0] ns_to_cycles(input int ns);
    return 12'((ns * `CLK_MHZ + 999) / 1000);
  endfunction
  localparam logic [11:0] ERASE_CYC = ns_to_cycles(ERASE_NS);
  localparam logic [11:0] PROG_CYC  = ns_to_cycles(PROGRAM_NS);

  wdog_pkg::store_e state, next_state;
  logic [11:0] timer, next_timer;
  logic [31:0] latch, next_latch;
  logic [15:0] next_wear;
  logic [7:0]  mem [4];

  assign busy = (state != wdog_pkg::ST_IDLE);

  // erase first, then program; each write taken adds one to wear, which holds at FFFF
  always_comb
  begin
    next_state = state;
    next_timer = timer;
    next_latch = latch;
    next_wear  = wear;
    case (state)
      wdog_pkg::ST_IDLE:
        if (wr_req)
        begin
          next_state = wdog_pkg::ST_ERASE;
          next_timer = ERASE_CYC - 12'h001;
          next_latch = wr_data;
          next_wear  = (wear == 16'hFFFF) ? wear : wear + 16'h0001;
        end
      wdog_pkg::ST_ERASE:
        if (timer == 12'h000)
        begin
          next_state = wdog_pkg::ST_PROGRAM;
          next_timer = PROG_CYC - 12'h001;
        end
        else
          next_timer = timer - 12'h001;
      wdog_pkg::ST_PROGRAM:
        if (timer == 12'h000)
          next_state = wdog_pkg::ST_IDLE;
        else
          next_timer = timer - 12'h001;
      default: next_state = wdog_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= wdog_pkg::ST_IDLE;
      timer   <= 12'h000;
      latch   <= 32'h00000000;
      wear    <= 16'h0000;
      rd_data <= 32'h00000000;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
      latch <= next_latch;
      wear  <= next_wear;
      if (rd_req)
        rd_data <= {mem[3], mem[2], mem[1], mem[0]};
    end
  end

  // array keeps its contents across resets, as flash would
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (state == wdog_pkg::ST_ERASE && timer == 12'h000)
        mem[i] <= 8'hFF;
      else if (state == wdog_pkg::ST_PROGRAM && timer == 12'h000)
        mem[i] <= latch[8*i +: 8];
    end
  end

  sequence s_write_taken;
    wr_req && !busy;
  endsequence
  a_store_busy: assert property (@(posedge clk) disable iff (!rst_n)
    s_write_taken |=> busy [*8])
    else $error("store not busy after write");
  a_wear_counts: assert property (@(posedge clk) disable iff (!rst_n)
    (s_write_taken and wear != 16'hFFFF) |=> wear == $past(wear) + 16'h0001)
    else $error("wear count did not advance");
endmodule

// [verilog/expiry_counter.sv]
// seconds counter cleared by host traffic, expiring at the period
`timescale 1ns/1ps
module expiry_counter (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  tick,
  input  wire logic  clear,
  wdog_cfg_if.dst    cfg_port,
  output logic       expire,
  output logic [15:0] count
);
  logic        active;
  logic        next_expire;
  logic [15:0] next_count;

  assign active = |cfg_port.cfg.options;

  // period zero never expires; the count just wraps
  always_comb
  begin
    next_expire = 1'b0;
    next_count  = count;
    if (clear || !active)
      next_count = 16'h0000;
    else if (tick)
    begin
      if (cfg_port.cfg.period != 16'h0000 &&
          count + 16'h0001 == cfg_port.cfg.period)
      begin
        next_expire = 1'b1;
        next_count  = 16'h0000;
      end
      else
        next_count = count + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count  <= 16'h0000;
      expire <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      expire <= next_expire;
    end
  end

  a_clear_zeroes: assert property (@(posedge clk) disable iff (!rst_n)
    clear |=> count == 16'h0000)
    else $error("count not cleared by host traffic");
  a_idle_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !active [*2] |-> count == 16'h0000)
    else $error("count moved while disabled");
  a_expire_cause: assert property (@(posedge clk) disable iff (!rst_n)
    expire |-> $past(tick) && !$past(clear) &&
      $past(count) + 16'h0001 == $past(cfg_port.cfg.period))
    else $error("expiry without reaching period");
endmodule

// [testbench/host_model.sv]
// host computer model: sends watchdog command packets and plain traffic
`timescale 1ns/1ps
module host_model (
  input  wire logic  clk,
  input  wire logic  rsp_valid,
  output logic       host_rx_pulse,
  output logic       cmd_valid,
  output logic [7:0]  cmd_group,
  output logic [7:0]  cmd_function,
  output logic [7:0]  cmd_write_select,
  output logic [7:0]  cmd_options,
  output logic [15:0] cmd_period,
  output logic [7:0]  cmd_line_config,
  output logic       got
);
  // quiet bus at time zero
  initial
  begin
    {host_rx_pulse, cmd_valid, got} = 3'h0;
    {cmd_group, cmd_function, cmd_write_select} = 24'h0;
    {cmd_options, cmd_period, cmd_line_config} = 32'h0;
  end

  // one packet; fields scrambled after so a stale value never helps
  // the bench never calls this while streaming, but sends rows 3 and 4 back to back
  // a line named in a line action is one this host already drives out
  task automatic send(input logic [7:0] g, f, w, o,
                      input logic [15:0] p, input logic [7:0] l);
    @(posedge clk);
    cmd_valid <= 1'b1;
    host_rx_pulse <= 1'b1;
    {cmd_group, cmd_function, cmd_write_select} <= {g, f, w};
    {cmd_options, cmd_period, cmd_line_config} <= {o, p, l};
    @(posedge clk);
    cmd_valid <= 1'b0;
    host_rx_pulse <= 1'b0;
    {cmd_group, cmd_function, cmd_write_select} <= ~{g, f, w};
    {cmd_options, cmd_period, cmd_line_config} <= ~{o, p, l};
    #1 got = rsp_valid;
  endtask

  // some other incoming transfer, as a host keeping the watchdog fed
  task automatic poke();
    @(posedge clk);
    host_rx_pulse <= 1'b1;
    @(posedge clk);
    host_rx_pulse <= 1'b0;
  endtask
endmodule

// [testbench/testbench.sv]
// self-checking bench for the host activity watchdog
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0]  g, f, w, o;
    logic [15:0] p;
    logic [7:0]  l, r, eo;
    logic [15:0] ep;
    logic [7:0]  el;
  } row_s;
  logic        clk, reset_n, second_tick, restore_jumper, stream_tx_pulse;
  logic        reg_write, reg_read, rsp_valid, device_reset_req, irq;
  logic        line_write, line_write_level, host_rx_pulse, cmd_valid, got;
  logic [7:0]  cmd_group, cmd_function, cmd_write_select, cmd_options;
  logic [7:0]  cmd_line_config, rsp_group, rsp_function, rsp_result;
  logic [7:0]  rsp_options, rsp_line_config, reg_addr;
  logic [15:0] cmd_period, rsp_period;
  logic [19:0] line_write_mask, last_mask;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic        last_lvl;
  int          num_errors, num_checks, n_rst, n_line;
  row_s        rows [6];
  row_s        r;

  host_model host (.clk(clk), .rsp_valid(rsp_valid),
    .host_rx_pulse(host_rx_pulse), .cmd_valid(cmd_valid),
    .cmd_group(cmd_group), .cmd_function(cmd_function),
    .cmd_write_select(cmd_write_select), .cmd_options(cmd_options),
    .cmd_period(cmd_period), .cmd_line_config(cmd_line_config), .got(got));

  host_activity_watchdog i_dut (.clk(clk), .reset_n(reset_n),
    .second_tick(second_tick), .restore_jumper(restore_jumper),
    .host_rx_pulse(host_rx_pulse), .stream_tx_pulse(stream_tx_pulse),
    .cmd_valid(cmd_valid), .cmd_group(cmd_group),
    .cmd_function(cmd_function), .cmd_write_select(cmd_write_select),
    .cmd_options(cmd_options), .cmd_period(cmd_period),
    .cmd_line_config(cmd_line_config), .rsp_valid(rsp_valid),
    .rsp_group(rsp_group), .rsp_function(rsp_function),
    .rsp_result(rsp_result), .rsp_options(rsp_options),
    .rsp_period(rsp_period), .rsp_line_config(rsp_line_config),
    .device_reset_req(device_reset_req), .line_write(line_write),
    .line_write_mask(line_write_mask), .line_write_level(line_write_level),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // tally action pulses; each stands one cycle only
  always @(posedge clk)
  begin
    if (device_reset_req === 1'b1) n_rst <= n_rst + 1;
    if (line_write === 1'b1)
    begin
      n_line <= n_line + 1;
      last_mask <= line_write_mask;
      last_lvl <= line_write_level;
    end
  end

  task automatic close_out();
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // boot wait covers sync, settle and a possible store of zeros
  task automatic power_up(input logic jmp);
    @(posedge clk);
    reset_n <= 1'b0;
    restore_jumper <= jmp;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (340) @(posedge clk);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_write <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // slow pin pulse, long enough for the two sync flops
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      second_tick <= 1'b1;
      repeat (6) @(posedge clk);
      second_tick <= 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask

  // store a one-second period, then one tick must fire the chosen actions
  task automatic act(input logic [7:0] o, l, input logic [19:0] m);
    int b_rst;
    int b_line;
    host.send(8'h05, 8'h09, 8'h01, o, 16'h0001, l);
    repeat (320) @(posedge clk);
    b_rst = n_rst;
    b_line = n_line;
    tick(1);
    chk(n_rst - b_rst, {31'h0, o[5]});
    chk(n_line - b_line, {31'h0, o[4]});
    if (o[4]) chk({last_lvl, last_mask}, {l[7], m});
  endtask

  initial
  begin
    {reset_n, second_tick, stream_tx_pulse, restore_jumper} = 4'h0;
    {reg_write, reg_read, reg_addr, reg_wdata} = 42'h0;
    n_rst = 0;
    n_line = 0;
    num_errors = 0;
    num_checks = 0;
    rows[0] = '{8'h05, 8'h09, 8'h00, 8'h20, 16'h0003, 8'h00,
                8'h00, 8'h00, 16'h0000, 8'h00};
    rows[1] = '{8'h04, 8'h09, 8'h01, 8'h20, 16'h0003, 8'h00,
                8'h01, 8'h00, 16'h0000, 8'h00};
    rows[2] = '{8'h05, 8'h08, 8'h01, 8'h20, 16'h0003, 8'h00,
                8'h01, 8'h00, 16'h0000, 8'h00};
    rows[3] = '{8'h05, 8'h09, 8'h01, 8'h20, 16'h0003, 8'h00,
                8'h00, 8'h20, 16'h0003, 8'h00};
    rows[4] = '{8'h05, 8'h09, 8'h01, 8'h10, 16'h0005, 8'h85,
                8'h02, 8'h20, 16'h0003, 8'h00};
    rows[5] = '{8'h05, 8'h09, 8'h00, 8'h00, 16'h0000, 8'h00,
                8'h00, 8'h20, 16'h0003, 8'h00};
    power_up(1'b1);
    // rows run back to back, so row 4 meets a busy store
    for (int i = 0; i < 6; i++)
    begin
      r = rows[i];
      host.send(r.g, r.f, r.w, r.o, r.p, r.l);
      chk(got, 1);
      chk({rsp_group, rsp_function}, 16'h0509);
      chk(rsp_result, r.r);
      chk({rsp_options, rsp_period, rsp_line_config},
          {r.eo, r.ep, r.el});
    end
    repeat (320) @(posedge clk);
    // reset action at the third second, not before
    tick(2);
    chk(n_rst, 0);
    tick(1);
    chk(n_rst, 1);
    chk(n_line, 0);
    // incoming traffic restarts the count, outgoing stream does not
    tick(2);
    host.poke();
    tick(2);
    chk(n_rst, 1);
    tick(1);
    chk(n_rst, 2);
    tick(2);
    @(posedge clk) stream_tx_pulse <= 1'b1;
    @(posedge clk) stream_tx_pulse <= 1'b0;
    tick(1);
    chk(n_rst, 3);
    act(8'h30, 8'h93, 20'h80000);
    act(8'h10, 8'h08, 20'h00100);
    act(8'h10, 8'h07, 20'h00080);
    reg_rd(8'h0C);
    chk(rd, 32'h07000110);
    // disabled: count pinned at zero, no actions
    act(8'h00, 8'h07, 20'h0);
    tick(2);
    reg_rd(8'h10);
    chk(rd[15:0], 16'h0);
    // sticky events, enable, clear, unmapped and read-only places
    reg_rd(8'h00);
    chk(rd, 32'h7);
    reg_wr(8'h08, 32'h1);
    #1 chk(irq, 1'b1);
    reg_wr(8'h04, 32'h1);
    reg_rd(8'h00);
    chk(irq, 1'b0);
    chk(rd, 32'h6);
    reg_wr(8'h08, 32'h6);
    reg_rd(8'h08);
    chk(irq, 1'b1);
    chk(rd, 32'h6);
    reg_wr(8'h04, 32'h6);
    reg_wr(8'h0C, 32'hFFFFFFFF);
    reg_rd(8'h0C);
    chk(irq, 1'b0);
    chk(rd, 32'h07000100);
    reg_rd(8'h20);
    chk(rd, 32'h0);
    // settings survive power-up unless the jumper is fitted
    host.send(8'h05, 8'h09, 8'h01, 8'h20, 16'h0005, 8'h03);
    repeat (320) @(posedge clk);
    power_up(1'b0);
    host.send(8'h05, 8'h09, 8'h00, 8'h00, 16'h0000, 8'h00);
    chk({rsp_options, rsp_period, rsp_line_config}, 32'h20000503);
    power_up(1'b1);
    host.send(8'h05, 8'h09, 8'h00, 8'h00, 16'h0000, 8'h00);
    chk({rsp_options, rsp_period, rsp_line_config}, 32'h0);
    close_out();
  end

  // cut a hang short
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("BAD %0t run did not finish", $time);
    close_out();
  end
endmodule
